// ==== hw/sfs_pkg.sv ====
package sfs_pkg;
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [1:0] SYNC_AGREE = 2'h3;
  localparam logic [1:0] SYNC_CLEAR = 2'h0;
  localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;
  localparam logic [2:0] SYNC_IDLE_LOW = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int CLK_DIV = 4;
  localparam logic [7:0] DIV_HALF = 8'h02;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] DIV_ONE = 8'h01;
  typedef enum logic [1:0] {
    SFS_IDLE = 2'b00,
    SFS_LOAD = 2'b01,
    SFS_SHIFT = 2'b10,
    SFS_END = 2'b11
  } sfs_host_state_t;
endpackage

// ==== hw/sfs_link_if.sv ====
`timescale 1ns/1ps
interface sfs_link_if;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  // wire level of the output line, floats high when undriven
  logic miso_wire;
  assign miso_wire = miso_oe ? miso : 1'b1;
  modport dev (input sel_n, input sclk, input mosi, output miso, output miso_oe);
  modport host (output sel_n, output sclk, output mosi, input miso_wire);
endinterface

// ==== hw/sfs_device.sv ====
`timescale 1ns/1ps
// Function
// - deselected: ignore inputs, output floats
// - standby when no internal operation runs
// - select low enables, enters active power
// - first command only after select falls
// - each operation starts on select falling
// - select rising ends the transaction
// - stay active until internal operation completes
// - input captured on rising clock edge
// - output updated on falling clock edge
module sfs_device
  import sfs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  sfs_link_if.dev LINK,
  input wire logic BUSY_IN,
  input wire logic [sfs_pkg::DATA_BITS-1:0] TX_BYTE_IN,
  output logic [sfs_pkg::CMD_BITS-1:0] CMD_OUT,
  output logic CMD_VALID_OUT,
  output logic [sfs_pkg::DATA_BITS-1:0] DATA_OUT,
  output logic DATA_VALID_OUT,
  output logic FRAME_END_OUT,
  output logic ACTIVE_OUT
);
  // link domain: clocked by the serial clock, reset while deselected except the byte toggle and arming flags
  logic frame_rst;
  logic [3:0] bit_cnt_reg;
  logic [DATA_BITS-1:0] shift_reg;
  logic [DATA_BITS-1:0] byte_reg;
  logic byte_tgl_reg;
  logic [DATA_BITS-1:0] tx_reg;
  logic miso_reg;
  logic [3:0] tx_cnt_reg;
  logic armed_meta_reg;
  logic armed_reg;
  // deselect doubles as reset of the link side, so a cut byte is dropped
  assign frame_rst = RST_IN | LINK.sel_n;

  // end of a byte, for either edge counter
  function automatic logic last_bit(input logic [3:0] cnt);
    last_bit = (cnt == BIT_CNT_LAST);
  endfunction

  // two synchroniser stages agree on one level
  function automatic logic stages_agree(input logic [2:0] stages);
    stages_agree = (stages[1] == stages[2]);
  endfunction

  // next values of the capture side
  wire byte_done = last_bit(bit_cnt_reg);
  wire [DATA_BITS-1:0] shift_next = {shift_reg[DATA_BITS-2:0], LINK.mosi};
  wire [3:0] bit_cnt_next = byte_done ? BIT_CNT_ZERO : bit_cnt_reg + BIT_CNT_ONE;

  // next values of the drive side; the next byte loads at the last fall of the
  // byte before, so its msb stands before the first rise that samples it
  // limitation: nothing useful goes out during the command byte
  wire tx_load = last_bit(tx_cnt_reg);
  wire [DATA_BITS-1:0] tx_src = tx_load ? TX_BYTE_IN : tx_reg;
  wire [DATA_BITS-1:0] tx_next = {tx_src[DATA_BITS-2:0], 1'b0};
  wire miso_next = tx_src[DATA_BITS-1];
  wire [3:0] tx_cnt_next = tx_load ? BIT_CNT_ZERO : tx_cnt_reg + BIT_CNT_ONE;

  // rising edge capture, msb first
  always_ff @(posedge LINK.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg <= BIT_CNT_ZERO;
      shift_reg <= BYTE_ZERO;
      byte_reg <= BYTE_ZERO;
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      if (byte_done) begin
        byte_reg <= shift_next;
      end
    end
  end

  // toggle survives deselect so no event is lost; async reset only by RST_IN
  always_ff @(posedge LINK.sclk or posedge RST_IN) begin
    if (RST_IN) begin
      byte_tgl_reg <= 1'b0;
    end else if (!LINK.sel_n && byte_done) begin
      byte_tgl_reg <= ~byte_tgl_reg;
    end
  end

  // falling edge drive, one bit per fall
  always_ff @(negedge LINK.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx_cnt_reg <= BIT_CNT_ZERO;
      tx_reg <= BYTE_ZERO;
      miso_reg <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      miso_reg <= miso_next;
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  assign LINK.miso = miso_reg;
  assign LINK.miso_oe = ~LINK.sel_n & armed_reg;

  // system domain: three-stage sync of select and byte toggle
  logic [2:0] sel_sync_reg;
  logic [2:0] tgl_sync_reg;
  logic sel_n_stable_reg;
  logic seen_fall_reg;
  logic tgl_seen_reg;
  logic cmd_pending_reg;
  // a change counts once the second and third stages agree
  wire sel_agree = stages_agree(sel_sync_reg);
  wire sel_fall = sel_agree & ~sel_sync_reg[1] & sel_n_stable_reg;
  wire sel_rise = sel_agree & sel_sync_reg[1] & ~sel_n_stable_reg;
  wire byte_evt = (tgl_sync_reg[2] != tgl_seen_reg) & stages_agree(tgl_sync_reg);
  // the first byte after a select fall is the command
  wire cmd_evt = byte_evt & cmd_pending_reg & seen_fall_reg;
  wire data_evt = byte_evt & ~cmd_pending_reg & seen_fall_reg;
  // busy comes from logic on this clock, so it needs no synchroniser
  wire active_next = ~sel_n_stable_reg | sel_fall | BUSY_IN;

  // armed after a select fall seen since reset; two stages, the flag is on
  // the system clock, so arming lags by two serial clock rises
  always_ff @(posedge LINK.sclk or posedge RST_IN) begin
    if (RST_IN) begin
      armed_meta_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      armed_meta_reg <= seen_fall_reg;
      armed_reg <= armed_meta_reg;
    end
  end

  // three-stage synchronisers; only the last two stages are ever compared
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_sync_reg <= SYNC_IDLE_HIGH;
      tgl_sync_reg <= SYNC_IDLE_LOW;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], LINK.sel_n};
      tgl_sync_reg <= {tgl_sync_reg[1:0], byte_tgl_reg};
    end
  end

  // frame tracking
  // a select fall wins over a byte event in the same cycle
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_n_stable_reg <= 1'b1;
      seen_fall_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      cmd_pending_reg <= 1'b0;
    end else begin
      if (sel_agree) begin
        sel_n_stable_reg <= sel_sync_reg[1];
      end
      if (sel_fall) begin
        seen_fall_reg <= 1'b1;
        cmd_pending_reg <= 1'b1;
      end else if (byte_evt && cmd_pending_reg) begin
        cmd_pending_reg <= 1'b0;
      end
      if (byte_evt) begin
        tgl_seen_reg <= tgl_sync_reg[2];
      end
    end
  end

  // command byte and its strobe
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CMD_OUT <= BYTE_ZERO;
      CMD_VALID_OUT <= 1'b0;
    end else begin
      CMD_VALID_OUT <= cmd_evt;
      if (cmd_evt) begin
        CMD_OUT <= byte_reg;
      end
    end
  end

  // data bytes; byte_reg holds until the next byte ends or a deselect clears it,
  // the next byte ends later than the toggle crosses, a deselect only with a host divider of 6 or more
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DATA_OUT <= BYTE_ZERO;
      DATA_VALID_OUT <= 1'b0;
    end else begin
      DATA_VALID_OUT <= data_evt;
      if (data_evt) begin
        DATA_OUT <= byte_reg;
      end
    end
  end

  // frame end and power state; standby follows a select rise only after
  // the synchroniser delay, active while selected or busy
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FRAME_END_OUT <= 1'b0;
      ACTIVE_OUT <= 1'b0;
    end else begin
      FRAME_END_OUT <= sel_rise;
      ACTIVE_OUT <= active_next;
    end
  end
endmodule

// ==== hw/sfs_host.sv ====
`timescale 1ns/1ps
module sfs_host
  import sfs_pkg::*;
#(
  parameter int DIV = sfs_pkg::CLK_DIV
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  sfs_link_if.host LINK,
  input wire logic START_IN,
  input wire logic [sfs_pkg::DATA_BITS-1:0] TX_BYTE_IN,
  input wire logic LAST_IN,
  output logic READY_OUT,
  output logic [sfs_pkg::DATA_BITS-1:0] RX_BYTE_OUT,
  output logic RX_VALID_OUT,
  output logic BUSY_OUT
);
  sfs_host_state_t state_reg;
  logic [7:0] div_reg;
  logic [3:0] bit_cnt_reg;
  logic [DATA_BITS-1:0] tx_reg;
  logic [DATA_BITS-1:0] rx_reg;
  logic last_reg;
  logic sclk_reg;
  logic sel_n_reg;
  wire tick = (div_reg == DIV_ZERO);
  wire [7:0] half = 8'(DIV / 2);

  // clock divider runs free, sclk toggles only while shifting; sclk idles low (mode 0)
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= SFS_IDLE;
      div_reg <= DIV_ZERO;
      bit_cnt_reg <= BIT_CNT_ZERO;
      tx_reg <= BYTE_ZERO;
      rx_reg <= BYTE_ZERO;
      last_reg <= 1'b0;
      sclk_reg <= 1'b0;
      sel_n_reg <= 1'b1;
      RX_BYTE_OUT <= BYTE_ZERO;
      RX_VALID_OUT <= 1'b0;
    end else begin
      RX_VALID_OUT <= 1'b0;
      div_reg <= tick ? half - DIV_ONE : div_reg - DIV_ONE;
      case (state_reg)
        SFS_IDLE: begin
          if (START_IN) begin
            sel_n_reg <= 1'b0;
            tx_reg <= TX_BYTE_IN;
            last_reg <= LAST_IN;
            bit_cnt_reg <= BIT_CNT_ZERO;
            state_reg <= SFS_SHIFT;
          end
        end
        SFS_LOAD: begin
          if (START_IN) begin
            tx_reg <= TX_BYTE_IN;
            last_reg <= LAST_IN;
            bit_cnt_reg <= BIT_CNT_ZERO;
            state_reg <= SFS_SHIFT;
          end
        end
        SFS_SHIFT: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (!sclk_reg) begin
              // rising edge: both sides sample here
              rx_reg <= {rx_reg[DATA_BITS-2:0], LINK.miso_wire};
            end else begin
              // falling edge: present next bit, valid at next rise
              tx_reg <= {tx_reg[DATA_BITS-2:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
              if (bit_cnt_reg == BIT_CNT_LAST) begin
                RX_BYTE_OUT <= rx_reg;
                RX_VALID_OUT <= 1'b1;
                state_reg <= last_reg ? SFS_END : SFS_LOAD;
              end
            end
          end
        end
        SFS_END: begin
          sel_n_reg <= 1'b1;
          state_reg <= SFS_IDLE;
        end
        default: begin
          state_reg <= SFS_IDLE;
        end
      endcase
    end
  end

  assign LINK.sclk = sclk_reg;
  assign LINK.sel_n = sel_n_reg;
  assign LINK.mosi = tx_reg[DATA_BITS-1];
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      READY_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      READY_OUT <= (state_reg == SFS_IDLE) | (state_reg == SFS_LOAD);
      BUSY_OUT <= (state_reg == SFS_SHIFT) | (state_reg == SFS_END) | ~sel_n_reg;
    end
  end
endmodule

// ==== bench/sfs_link_monitor.sv ====
`timescale 1ns/1ps
// link and power-state watcher; select is synchronised, so windows allow slack
module sfs_link_monitor (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic BUSY_IN,
  input wire logic ACTIVE_OUT,
  input wire logic FRAME_END_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  AST_DESEL_FLOAT: assert property (sel_n [*4] |-> !miso_oe)
    else $error("output driven while deselected");
  AST_STANDBY: assert property ((sel_n && !BUSY_IN) [*6] |-> !ACTIVE_OUT)
    else $error("no standby while idle");
  AST_ACTIVE: assert property (!sel_n [*5] |-> ACTIVE_OUT)
    else $error("not active while selected");
  AST_IDLE_CLK: assert property (sel_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  AST_END: assert property ($rose(sel_n) |-> ##[1:6] FRAME_END_OUT)
    else $error("no frame end after select rise");
  AST_BUSY_HOLD: assert property (BUSY_IN [*4] |-> ACTIVE_OUT)
    else $error("standby during internal operation");
  AST_IN_STABLE: assert property (sclk |-> $stable(mosi))
    else $error("input line moved while clock high");
  AST_OUT_FALL: assert property ($changed(miso) && miso_oe && $past(miso_oe) |-> !sclk)
    else $error("output line moved while clock high");
endmodule

// ==== bench/serial_flash_select_framing_tb.sv ====
`timescale 1ns/1ps
module serial_flash_select_framing_tb;
  import sfs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic last = 1'b0;
  logic busy = 1'b0;
  logic [7:0] htx = 8'h00;
  logic [7:0] dtx = 8'h00;
  logic [7:0] cmd, dat, rx, b;
  logic cmd_v, dat_v, rx_v, rdy, act, fe;
  logic [7:0] q_cmd[$], q_dat[$], q_rx[$];
  int failures = 0;
  int compares = 0;
  int seed = 32'h9eb50f10;
  int nrx = 0;
  int wn = 0;
  logic hbusy;
  always #2 clk = ~clk;
  sfs_link_if sfs_link_if_inst();
  sfs_device sfs_device_inst (.CLK_IN(clk), .RST_IN(rst), .LINK(sfs_link_if_inst),
    .BUSY_IN(busy), .TX_BYTE_IN(dtx), .CMD_OUT(cmd), .CMD_VALID_OUT(cmd_v), .DATA_OUT(dat),
    .DATA_VALID_OUT(dat_v), .FRAME_END_OUT(fe), .ACTIVE_OUT(act));
  // slow divider keeps the output change well inside the low half
  sfs_host #(.DIV(12)) sfs_host_inst (.CLK_IN(clk), .RST_IN(rst), .LINK(sfs_link_if_inst),
    .START_IN(start), .TX_BYTE_IN(htx), .LAST_IN(last), .READY_OUT(rdy),
    .RX_BYTE_OUT(rx), .RX_VALID_OUT(rx_v), .BUSY_OUT(hbusy));
  sfs_link_monitor sfs_link_monitor_inst (.CLK_IN(clk), .RST_IN(rst),
    .sel_n(sfs_link_if_inst.sel_n), .sclk(sfs_link_if_inst.sclk),
    .mosi(sfs_link_if_inst.mosi), .miso(sfs_link_if_inst.miso),
    .miso_oe(sfs_link_if_inst.miso_oe), .BUSY_IN(busy), .ACTIVE_OUT(act), .FRAME_END_OUT(fe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one byte per call; an edge always passes before start rises again
  task automatic send(input logic [7:0] v, input logic l);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rdy !== 1'b1 && n < 2000);
    if (n == 2000) begin
      failures++;
      wrap_up();
    end
    start = 1'b1;
    htx = v;
    last = l;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask
  // oldest note against each reported byte; first reply of a frame is undefined
  always @(posedge clk) begin
    if (cmd_v === 1'b1) check(cmd, q_cmd.size() ? q_cmd.pop_front() : ~cmd);
    if (dat_v === 1'b1) check(dat, q_dat.size() ? q_dat.pop_front() : ~dat);
    if (rx_v === 1'b1) begin
      if (nrx > 0) check(rx, q_rx.size() ? q_rx.pop_front() : ~rx);
      nrx++;
    end
    if (sfs_link_if_inst.sel_n === 1'b1) nrx = 0;
  end
  // frames of two to four bytes, the last one during an internal operation
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    for (int f = 0; f < 6; f++) begin
      dtx = $random(seed);
      busy = (f == 5);
      for (int i = 0; i < 2 + f % 3; i++) begin
        b = $random(seed);
        if (i == 0) q_cmd.push_back(b);
        else begin
          q_dat.push_back(b);
          q_rx.push_back(dtx);
        end
        send(b, i == 1 + f % 3);
      end
      // the frame is still shifting when the last send returns
      wn = 0;
      while (sfs_link_if_inst.sel_n !== 1'b1 && wn < 2000) begin
        @(posedge clk);
        #1;
        wn++;
      end
      if (wn == 2000) begin
        failures++;
        wrap_up();
      end
      repeat (20) @(posedge clk);
      #1;
      check(act, busy);
    end
    busy = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check(act, 1'b0);
    check(sfs_link_if_inst.miso_wire, 1'b1);
    check({7'h00, hbusy}, 8'h00);
    check(8'(q_cmd.size() + q_dat.size() + q_rx.size()), 8'h00);
    wrap_up();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
